// ---- design/pps_pkg.sv ----
package pps_pkg;

	// Timebase
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
	localparam int TMR_W = 16;

	// Fixed delays in milliseconds, then in ticks
	localparam int IFACE_OPEN_MS = 500;
	localparam int BAR_WARN_MS = 2000;
	localparam int BAR_DEACT_MS = 60000;
	localparam int PEER_SILENT_MS = 3000;
	localparam logic [TMR_W-1:0] IFACE_OPEN_TICKS = TMR_W'(IFACE_OPEN_MS / TICK_MS);
	localparam logic [TMR_W-1:0] BAR_WARN_TICKS = TMR_W'(BAR_WARN_MS / TICK_MS);
	localparam logic [TMR_W-1:0] BAR_DEACT_TICKS = TMR_W'(BAR_DEACT_MS / TICK_MS);
	localparam logic [TMR_W-1:0] PEER_SILENT_TICKS = TMR_W'(PEER_SILENT_MS / TICK_MS);

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_REV_SYNC_MAX = 8'h04;
	localparam logic [7:0] REG_LINE_DELAY = 8'h08;
	localparam logic [7:0] REG_FW_VERSION = 8'h0c;
	localparam logic [7:0] REG_EVT_STATUS = 8'h10;
	localparam logic [7:0] REG_EVT_ACK = 8'h14;
	localparam logic [7:0] REG_REPORT = 8'h18;

	// Control field positions
	localparam int CTRL_PARALLEL = 0;
	localparam int CTRL_MB_SYNC = 1;
	localparam int CTRL_HOT_EN = 2;
	localparam int CTRL_ROLE_MASTER = 3;
	localparam int CTRL_ROLE_BACKUP = 4;
	localparam int CTRL_MODE_LO = 8;
	localparam int CTRL_MODE_HI = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_0100;
	localparam logic [31:0] CTRL_MASK = 32'h0000_1f1f;
	localparam logic [15:0] FW_VERSION_RST = 16'h0001;

	// Operating modes
	typedef enum logic [4:0] {
		MODE_OFF = 5'b00001,
		MODE_MANUAL = 5'b00010,
		MODE_AUTO = 5'b00100,
		MODE_TEST = 5'b01000,
		MODE_REMOTE = 5'b10000
	} pps_mode_t;

	// Severity classes
	typedef enum logic [2:0] {
		SEV_NONE = 3'h0,
		SEV_WARNING = 3'h1,
		SEV_DEACT = 3'h2,
		SEV_ALARM = 3'h3
	} pps_sev_t;

	// Event indices
	localparam int EV_N = 11;
	localparam int EV_REV_SYNC = 0;
	localparam int EV_PARAM = 1;
	localparam int EV_LINE_OPEN = 2;
	localparam int EV_IFACE = 3;
	localparam int EV_FORCED = 4;
	localparam int EV_BUS_BAR = 5;
	localparam int EV_RED_CFG = 6;
	localparam int EV_MASTER_FAIL = 7;
	localparam int EV_RELAY = 8;
	localparam int EV_FW = 9;
	localparam int EV_BACKUP_FAIL = 10;

	// Event identifiers per index
	localparam logic [8:0] EV_CODE [EV_N] = '{
		9'h110, 9'h111, 9'h112, 9'h113, 9'h114, 9'h117,
		9'h11a, 9'h11b, 9'h11c, 9'h11d, 9'h11e
	};

	// Persistence timers
	localparam int TM_N = 5;
	localparam int TM_REV_SYNC = 0;
	localparam int TM_LINE = 1;
	localparam int TM_IFACE = 2;
	localparam int TM_BAR = 3;
	localparam int TM_SILENT = 4;

	// Plant pins, asynchronous
	typedef struct packed {
		logic mains_fail;
		logic iface_closed;
		logic gen_paralleled;
		logic line_open_di;
		logic relay_fb;
		logic bar_voltage;
		logic mains_breaker_closed;
		logic mains_live;
	} pps_pins_t;
	localparam int PIN_W = $bits(pps_pins_t);

	// Messages from bus logic, same clock
	typedef struct packed {
		logic sync_busy;
		logic peer_gen_closed;
		logic forced_evt;
		logic forced_alarm;
		logic master_fail;
		logic own_command;
		logic peer_msg;
		logic need_gen_close;
		logic [15:0] peer_fw;
	} pps_msg_t;

	// Event report
	typedef struct packed {
		logic any;
		logic [8:0] id;
		pps_sev_t sev;
	} pps_report_t;

endpackage

// ---- design/pps_supervisor.sv ----
`timescale 1ns/1ps
// Function
// - Warn when mains-breaker sync overruns
// - Zero maximum sync time disables check
// - Sync check inhibited when not permitted
// - Sync check only in auto/test/remote
// - Incoherent plant parameters raise event always
// - Line-open input held for delay deactivates
// - Zero line-open delay disables protection
// - Interface breaker not open in 0.5s
// - Master-forced event raised on receipt
// - Expected bar voltage absent two seconds
// - Only missing expected voltage flagged
// - Escalate bar warning after sixty seconds in auto/test/remote
// - Invalid redundancy configuration raises alarm
// - Backup takes control on master failure
// - Warn on changeover relay feedback mismatch
// - Firmware mismatch alarms, redundancy unavailable
// - Master warns when backup goes silent
// - Redundancy anomalies off when disabled
module pps_supervisor
	import pps_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Plant and bus inputs
	input wire pps_pins_t pins_i,
	input wire pps_msg_t msg_i,
	// Events and actions
	output logic [EV_N-1:0] event_active_o,
	output pps_report_t report_o,
	output logic take_control_o,
	output logic redundancy_ok_o
);

	logic [31:0] ctrl_q;
	logic [TMR_W-1:0] rev_sync_max_q;
	logic [TMR_W-1:0] line_delay_q;
	logic [15:0] fw_version_q;
	logic [31:0] wmask;
	logic wr_stb;
	logic [EV_N-1:0] ack_pulse_q;
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
	pps_pins_t pin;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [TM_N-1:0] tm_run;
	logic [TMR_W-1:0] tm_cnt_q [TM_N];
	logic [EV_N-1:0] cond;
	logic [EV_N-1:0] cond_prev_q;
	logic [EV_N-1:0] active_q;
	pps_sev_t sev [EV_N];
	pps_mode_t mode;
	logic sync_mode, auto_mode, hot_en, role_master, role_backup;
	logic bar_expected, bar_escalate;
	logic [31:0] rd_d;
	pps_report_t report_d;

	// Control decode
	assign mode = pps_mode_t'(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]);
	assign hot_en = ctrl_q[CTRL_HOT_EN];
	assign role_master = ctrl_q[CTRL_ROLE_MASTER];
	assign role_backup = ctrl_q[CTRL_ROLE_BACKUP];
	assign sync_mode = (mode == MODE_AUTO) || (mode == MODE_TEST) || (mode == MODE_REMOTE);
	assign auto_mode = sync_mode;

	// Wishbone byte lanes
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= CTRL_RST;
			rev_sync_max_q <= '0;
			line_delay_q <= '0;
			fw_version_q <= FW_VERSION_RST;
		end
		else if (wr_stb)
		begin
			unique case (wb_adr_i)
				REG_CTRL:
				begin
					ctrl_q <= ((ctrl_q & ~wmask) | (wb_dat_i & wmask)) & CTRL_MASK;
				end
				REG_REV_SYNC_MAX:
				begin
					rev_sync_max_q <= (rev_sync_max_q & ~wmask[TMR_W-1:0])
						| (wb_dat_i[TMR_W-1:0] & wmask[TMR_W-1:0]);
				end
				REG_LINE_DELAY:
				begin
					line_delay_q <= (line_delay_q & ~wmask[TMR_W-1:0])
						| (wb_dat_i[TMR_W-1:0] & wmask[TMR_W-1:0]);
				end
				REG_FW_VERSION:
				begin
					fw_version_q <= (fw_version_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				end
				default:
				begin
				end
			endcase
		end
	end

	// Acknowledge strobes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_pulse_q <= '0;
		end
		else if (wr_stb && wb_adr_i == REG_EVT_ACK)
		begin
			ack_pulse_q <= wb_dat_i[EV_N-1:0] & wmask[EV_N-1:0];
		end
		else
		begin
			ack_pulse_q <= '0;
		end
	end

	// Read mux
	always_comb
	begin
		rd_d = '0;
		unique case (wb_adr_i)
			REG_CTRL: rd_d = ctrl_q;
			REG_REV_SYNC_MAX: rd_d[TMR_W-1:0] = rev_sync_max_q;
			REG_LINE_DELAY: rd_d[TMR_W-1:0] = line_delay_q;
			REG_FW_VERSION: rd_d[15:0] = fw_version_q;
			REG_EVT_STATUS: rd_d[EV_N-1:0] = active_q;
			REG_REPORT: rd_d[$bits(pps_report_t)-1:0] = report_o;
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_dat_o <= '0;
		end
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
		begin
			wb_dat_o <= rd_d;
		end
	end

	// Pin synchronisers with agreement filter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end
		else
		begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		end
	end
	assign pin = pps_pins_t'(pin_q);

	// Timebase tick
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == 32'(TICK_LEN - 1))
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// Timer run conditions
	// Expected but missing voltage
	assign bar_expected = msg_i.peer_gen_closed || (pin.mains_breaker_closed && pin.mains_live);
	always_comb
	begin
		tm_run[TM_REV_SYNC] = msg_i.sync_busy && ctrl_q[CTRL_PARALLEL] && ctrl_q[CTRL_MB_SYNC]
			&& sync_mode;
		tm_run[TM_LINE] = pin.line_open_di;
		tm_run[TM_IFACE] = pin.mains_fail && pin.gen_paralleled && pin.iface_closed;
		tm_run[TM_BAR] = msg_i.need_gen_close && bar_expected && !pin.bar_voltage;
		tm_run[TM_SILENT] = hot_en && role_master && !msg_i.peer_msg;
	end

	// Persistence timers
	genvar t;
	generate
		for (t = 0; t < TM_N; t++)
		begin : g_tmr
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					tm_cnt_q[t] <= '0;
				end
				else if (!tm_run[t])
				begin
					tm_cnt_q[t] <= '0;
				end
				else if (tick_q && tm_cnt_q[t] != '1)
				begin
					tm_cnt_q[t] <= tm_cnt_q[t] + TMR_W'(1);
				end
			end
		end
	endgenerate

	// Event conditions
	always_comb
	begin
		cond[EV_REV_SYNC] = tm_run[TM_REV_SYNC] && rev_sync_max_q != '0
			&& tm_cnt_q[TM_REV_SYNC] >= rev_sync_max_q;
		cond[EV_PARAM] = ctrl_q[CTRL_MB_SYNC] && !ctrl_q[CTRL_PARALLEL];
		cond[EV_LINE_OPEN] = tm_run[TM_LINE] && line_delay_q != '0
			&& tm_cnt_q[TM_LINE] >= line_delay_q;
		cond[EV_IFACE] = tm_run[TM_IFACE] && tm_cnt_q[TM_IFACE] >= IFACE_OPEN_TICKS;
		cond[EV_FORCED] = msg_i.forced_evt;
		cond[EV_BUS_BAR] = tm_run[TM_BAR] && tm_cnt_q[TM_BAR] >= BAR_WARN_TICKS;
		cond[EV_RED_CFG] = hot_en && (role_master == role_backup);
		cond[EV_MASTER_FAIL] = hot_en && role_backup && msg_i.master_fail;
		cond[EV_RELAY] = hot_en && (msg_i.own_command != pin.relay_fb);
		cond[EV_FW] = hot_en && (msg_i.peer_fw != fw_version_q);
		cond[EV_BACKUP_FAIL] = tm_run[TM_SILENT] && tm_cnt_q[TM_SILENT] >= PEER_SILENT_TICKS;
	end

	assign bar_escalate = auto_mode && tm_cnt_q[TM_BAR] >= BAR_DEACT_TICKS;

	// Severity per event
	always_comb
	begin
		sev[EV_REV_SYNC] = SEV_WARNING;
		sev[EV_PARAM] = SEV_ALARM;
		sev[EV_LINE_OPEN] = SEV_DEACT;
		sev[EV_IFACE] = SEV_ALARM;
		sev[EV_FORCED] = msg_i.forced_alarm ? SEV_ALARM : SEV_WARNING;
		sev[EV_BUS_BAR] = bar_escalate ? SEV_DEACT : SEV_WARNING;
		sev[EV_RED_CFG] = SEV_ALARM;
		sev[EV_MASTER_FAIL] = SEV_WARNING;
		sev[EV_RELAY] = SEV_WARNING;
		sev[EV_FW] = SEV_ALARM;
		sev[EV_BACKUP_FAIL] = SEV_WARNING;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cond_prev_q <= '0;
			active_q <= '0;
		end
		else
		begin
			cond_prev_q <= cond;
			active_q <= (cond & ~cond_prev_q) | (active_q & cond & ~ack_pulse_q);
		end
	end
	assign event_active_o = active_q;

	always_comb
	begin
		report_d = '{any: 1'b0, id: 9'h000, sev: SEV_NONE};
		for (int e = EV_N - 1; e >= 0; e--)
		begin
			if (active_q[e])
			begin
				report_d = '{any: 1'b1, id: EV_CODE[e], sev: sev[e]};
			end
		end
	end

	// Actions
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			report_o <= '{any: 1'b0, id: 9'h000, sev: SEV_NONE};
			take_control_o <= 1'b0;
			redundancy_ok_o <= 1'b0;
		end
		else
		begin
			report_o <= report_d;
			take_control_o <= cond[EV_MASTER_FAIL];
			redundancy_ok_o <= hot_en && !cond[EV_FW] && !cond[EV_RED_CFG];
		end
	end

endmodule

// ---- testbench/pps_chk.sv ----
`timescale 1ns/1ps
module pps_chk
	import pps_pkg::*;
#(
	parameter int TICK_LEN = 10
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Plant and events
	input wire pps_pins_t pins_i,
	input wire pps_msg_t msg_i,
	input wire logic [EV_N-1:0] event_active_o,
	input wire pps_report_t report_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	a_ack_pulse:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_ack_answer:
	assert property (req |=> wb_ack_o) else $error("no ack after request");
	a_forced_set:
	assert property ($rose(msg_i.forced_evt) |=> event_active_o[EV_FORCED])
		else $error("forced event not raised");
	a_forced_drop:
	assert property ($fell(msg_i.forced_evt) |=> !event_active_o[EV_FORCED])
		else $error("forced event not dropped");
	a_ack_clears:
	assert property (req && wb_we_i && wb_adr_i == REG_EVT_ACK && wb_sel_i[0]
		&& wb_dat_i[EV_FORCED] && $stable(msg_i.forced_evt)
		|-> ##3 !event_active_o[EV_FORCED]) else $error("ack did not clear");
	a_report_any:
	assert property (report_o.any == |$past(event_active_o))
		else $error("report any wrong");
	a_line_sev:
	assert property (report_o.any && report_o.id == EV_CODE[EV_LINE_OPEN]
		|-> report_o.sev == SEV_DEACT) else $error("line severity wrong");
	a_param_sev:
	assert property (report_o.any && report_o.id == EV_CODE[EV_PARAM]
		|-> report_o.sev == SEV_ALARM) else $error("param severity wrong");
	a_iface_persist:
	assert property ($rose(event_active_o[EV_IFACE]) |-> $past(pins_i.mains_fail, 4 * TICK_LEN)
		&& $past(pins_i.gen_paralleled, 4 * TICK_LEN)) else $error("iface alarm early");

	c_bar: cover property ($rose(event_active_o[EV_BUS_BAR]));
	c_esc: cover property (report_o.any && report_o.sev == SEV_DEACT);
	c_mfail: cover property ($rose(event_active_o[EV_MASTER_FAIL]));
endmodule

bind pps_supervisor pps_chk #(.TICK_LEN(TICK_LEN)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
	.msg_i(msg_i), .event_active_o(event_active_o), .report_o(report_o));

// ---- testbench/pps_plant.sv ----
`timescale 1ns/1ps
module pps_plant
	import pps_pkg::*;
(
	// Clock, reset, wanted states
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pps_pins_t want_i,
	input wire logic slow_i,
	// Pins to the block
	output pps_pins_t pins_o
);
	logic [7:0] fail_q;
	// Time since mains failure
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !want_i.mains_fail)
			fail_q <= 8'h00;
		else if (fail_q != 8'hff)
			fail_q <= fail_q + 8'h01;
	end
	always_comb
	begin
		pins_o = want_i;
		pins_o.iface_closed = want_i.iface_closed
			&& !(want_i.mains_fail && fail_q >= (slow_i ? 8'h50 : 8'h14));
	end
endmodule

// ---- testbench/plant_protection_supervisor_tb_top.sv ----
`timescale 1ns/1ps
module plant_protection_supervisor_tb_top;
	import pps_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, slow, tc, rok;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, rd, r;
	logic [EV_N-1:0] ev;
	pps_pins_t pw, pins;
	pps_msg_t m;
	pps_report_t rep;
	int miscompares, n_tests;

	pps_plant u_plant (.clk_i(clk_i), .rst_i(rst_i), .want_i(pw), .slow_i(slow), .pins_o(pins));
	pps_supervisor #(.TICK_LEN(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .pins_i(pins), .msg_i(m), .event_active_o(ev),
		.report_o(rep), .take_control_o(tc), .redundancy_ok_o(rok));

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task conclude();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= 4'hf;
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge clk_i);
		r = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (i == 20)
		begin
			miscompares++;
			conclude();
		end
	endtask

	task watch(input int b, input logic e, input int n);
		for (int i = 0; i < n && ev[b] !== 1'b1; i++)
			@(posedge clk_i);
		check(32'(ev[b]), 32'(e));
		if (e && ev[b] !== 1'b1)
			conclude();
	endtask

	task crep(input int b, input pps_sev_t s);
		@(posedge clk_i);
		check(32'(rep), 32'({1'b1, EV_CODE[b], s}));
	endtask

	task t_regs();
		bus(1'b0, REG_CTRL, 32'h0);
		check(r, CTRL_RST);
		bus(1'b0, REG_FW_VERSION, 32'h0);
		check(r, 32'(FW_VERSION_RST));
		bus(1'b1, 8'h20, 32'hffff_ffff);
		bus(1'b0, 8'h20, 32'h0);
		check(r, 32'h0);
	endtask

	task t_param();
		bus(1'b1, REG_CTRL, 32'h0000_0102);
		watch(EV_PARAM, 1'b1, 10);
		crep(EV_PARAM, SEV_ALARM);
		bus(1'b0, REG_EVT_STATUS, 32'h0);
		check(r, 32'h0000_0002);
		bus(1'b0, REG_REPORT, 32'h0);
		check(r, 32'({1'b1, EV_CODE[EV_PARAM], SEV_ALARM}));
		bus(1'b1, REG_CTRL, 32'h0000_0103);
		repeat (3) @(posedge clk_i);
		check(32'(ev[EV_PARAM]), 32'h0);
	endtask

	task t_line();
		pw.line_open_di <= 1'b1;
		watch(EV_LINE_OPEN, 1'b0, 80);
		pw.line_open_di <= 1'b0;
		repeat (10) @(posedge clk_i);
		bus(1'b1, REG_LINE_DELAY, 32'h3);
		pw.line_open_di <= 1'b1;
		repeat (15) @(posedge clk_i);
		pw.line_open_di <= 1'b0;
		watch(EV_LINE_OPEN, 1'b0, 40);
		pw.line_open_di <= 1'b1;
		watch(EV_LINE_OPEN, 1'b1, 60);
		crep(EV_LINE_OPEN, SEV_DEACT);
		bus(1'b1, REG_EVT_ACK, 32'h4);
		repeat (3) @(posedge clk_i);
		check(32'(ev[EV_LINE_OPEN]), 32'h0);
		pw.line_open_di <= 1'b0;
	endtask

	task t_rev();
		logic [31:0] rc [6];
		rc = '{32'h403, 32'h803, 32'h1003, 32'h203, 32'h103, 32'h401};
		bus(1'b1, REG_REV_SYNC_MAX, 32'h4);
		for (int k = 0; k < 7; k++)
		begin
			if (k == 6)
				bus(1'b1, REG_REV_SYNC_MAX, 32'h0);
			bus(1'b1, REG_CTRL, rc[k % 6]);
			m.sync_busy <= 1'b1;
			watch(EV_REV_SYNC, k < 3, 80);
			m.sync_busy <= 1'b0;
			repeat (5) @(posedge clk_i);
		end
	endtask

	task t_iface();
		pw.gen_paralleled <= 1'b1;
		pw.iface_closed <= 1'b1;
		pw.mains_fail <= 1'b1;
		watch(EV_IFACE, 1'b0, 100);
		pw.mains_fail <= 1'b0;
		slow <= 1'b1;
		repeat (10) @(posedge clk_i);
		pw.mains_fail <= 1'b1;
		watch(EV_IFACE, 1'b1, 100);
		pw.mains_fail <= 1'b0;
		pw.gen_paralleled <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask

	task t_forced();
		m.forced_alarm <= 1'b1;
		m.forced_evt <= 1'b1;
		watch(EV_FORCED, 1'b1, 5);
		crep(EV_FORCED, SEV_ALARM);
		bus(1'b1, REG_EVT_ACK, 32'h10);
		repeat (2) @(posedge clk_i);
		check(32'(ev[EV_FORCED]), 32'h0);
		m.forced_evt <= 1'b0;
		m.forced_alarm <= 1'b0;
		repeat (2) @(posedge clk_i);
		m.forced_evt <= 1'b1;
		watch(EV_FORCED, 1'b1, 5);
		crep(EV_FORCED, SEV_WARNING);
		m.forced_evt <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task t_bar();
		bus(1'b1, REG_CTRL, 32'h403);
		m.need_gen_close <= 1'b1;
		pw.bar_voltage <= 1'b1;
		watch(EV_BUS_BAR, 1'b0, 300);
		pw.bar_voltage <= 1'b0;
		m.peer_gen_closed <= 1'b1;
		watch(EV_BUS_BAR, 1'b1, 300);
		crep(EV_BUS_BAR, SEV_WARNING);
		repeat (5900) @(posedge clk_i);
		crep(EV_BUS_BAR, SEV_DEACT);
		m.need_gen_close <= 1'b0;
		m.peer_gen_closed <= 1'b0;
	endtask

	task t_red();
		bus(1'b1, REG_CTRL, 32'h11c);
		watch(EV_RED_CFG, 1'b1, 10);
		bus(1'b1, REG_CTRL, 32'h108);
		m.peer_fw <= 16'h0002;
		m.peer_msg <= 1'b0;
		m.own_command <= 1'b1;
		m.master_fail <= 1'b1;
		watch(EV_BACKUP_FAIL, 1'b0, 400);
		check(32'(ev[10:6]), 32'h0);
		bus(1'b1, REG_CTRL, 32'h10c);
		watch(EV_FW, 1'b1, 20);
		check(32'(rok), 32'h0);
		watch(EV_RELAY, 1'b1, 20);
		watch(EV_BACKUP_FAIL, 1'b1, 400);
		bus(1'b1, REG_CTRL, 32'h114);
		watch(EV_MASTER_FAIL, 1'b1, 20);
		repeat (2) @(posedge clk_i);
		check(32'(tc), 32'h1);
		m.peer_fw <= 16'h0001;
		repeat (2) @(posedge clk_i);
		check(32'(rok), 32'h1);
	endtask

	initial
	begin
		miscompares = 0;
		n_tests = 0;
		rst_i = 1'b1;
		{cyc, stb, we, slow, adr, sel, wd} = '0;
		pw = '0;
		m = '0;
		m.peer_fw = 16'h0001;
		m.peer_msg = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_param();
		t_line();
		t_rev();
		t_iface();
		t_forced();
		t_bar();
		t_red();
		conclude();
	end
endmodule
